//--- design/dms_sequencer.sv
/*
 * Drive mode sequencer: parameter file, jog, speed control, profile
 * positioning setpoint handshake and status word.
 * Assumes a motion core that reports standstill, target reached, halt,
 * error and reference state on the core clock, and jog pins that are
 * asynchronous to it.
 */
module dms_sequencer
	import dms_pkg::*;
(
	// Clock and reset
	input  wire logic                core_clk_i,
	input  wire logic                rst_b_i,
	// Parameter access
	input  wire logic                par_wr_i,
	input  wire logic                par_rd_i,
	input  wire logic [15:0]         par_addr_i,
	input  wire logic [31:0]         par_wdata_i,
	output logic      [31:0]         par_rdata_o,
	// Jog digital inputs
	input  wire logic                jog_src_io_i,
	input  wire logic                jog_pos_pin_i,
	input  wire logic                jog_neg_pin_i,
	input  wire logic                jog_fast_pin_i,
	// Motion core feedback
	input  wire dms_motion_fb_t      fb_i,
	input  wire logic [15:0]         max_speed_i,
	// Motion commands and status
	output logic      [15:0]         status_word_o,
	output logic                     jog_run_o,
	output logic                     jog_neg_o,
	output logic                     jog_fast_o,
	output logic                     speed_active_o,
	output logic signed [15:0]       speed_ref_o,
	output logic                     pos_load_o,
	output dms_pos_set_t             pos_set_o
);

	// ------------------------------------------------------------
	// Parameter file
	// ------------------------------------------------------------
	logic [2:0]         jog_q, jog_d;
	logic [15:0]        ctrl_q, ctrl_d, mode_q, mode_d;
	logic [15:0]        src_q, src_d;
	logic signed [15:0] sset_q, sset_d;
	logic [31:0]        tgt_q, tgt_d, pspd_q, pspd_d;
	logic [31:0]        acc_q, acc_d, dec_q, dec_d, rdata_q, rdata_d;
	logic               src_wr;
	logic signed [15:0] wr_s16;

	assign src_wr = par_wr_i && (par_addr_i == ADDR_SPD_SRC);
	assign wr_s16 = signed'(par_wdata_i[15:0]);

	always_comb begin
		jog_d   = jog_q;
		ctrl_d  = ctrl_q;
		mode_d  = mode_q;
		src_d   = src_q;
		sset_d  = sset_q;
		tgt_d   = tgt_q;
		pspd_d  = pspd_q;
		acc_d   = acc_q;
		dec_d   = dec_q;
		rdata_d = rdata_q;
		if (par_wr_i) begin
			case (par_addr_i)
				ADDR_JOG_REQ: jog_d  = par_wdata_i[2:0];
				ADDR_CTRL:    ctrl_d = par_wdata_i[15:0];
				ADDR_MODE:    mode_d = par_wdata_i[15:0];
				ADDR_TGT_POS: tgt_d  = par_wdata_i;
				ADDR_POS_SPD: pspd_d = par_wdata_i;
				ADDR_ACCEL:   acc_d  = par_wdata_i;
				ADDR_DECEL:   dec_d  = par_wdata_i;
				ADDR_SPD_SRC: begin
					if (par_wdata_i[15:0] == SRC_NONE ||
					    par_wdata_i[15:0] == SRC_PARAM) begin
						src_d = par_wdata_i[15:0];
					end
				end
				ADDR_SPD_SET: begin
					if (wr_s16 <= signed'(SPD_LIMIT[15:0]) &&
					    wr_s16 >= -signed'(SPD_LIMIT[15:0])) begin
						sset_d = wr_s16;
					end
				end
				default: ;
			endcase
		end
		if (par_rd_i) begin
			case (par_addr_i)
				ADDR_JOG_REQ: rdata_d = {29'h0, jog_q};
				ADDR_CTRL:    rdata_d = {16'h0, ctrl_q};
				ADDR_STATUS:  rdata_d = {16'h0, status_word_o};
				ADDR_MODE:    rdata_d = {16'h0, mode_q};
				ADDR_TGT_POS: rdata_d = tgt_q;
				ADDR_POS_SPD: rdata_d = pspd_q;
				ADDR_ACCEL:   rdata_d = acc_q;
				ADDR_DECEL:   rdata_d = dec_q;
				ADDR_SPD_SRC: rdata_d = {16'h0, src_q};
				ADDR_SPD_SET: rdata_d = {16'h0, sset_q};
				default:      rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			jog_q   <= RST_JOG;
			ctrl_q  <= RST_CTRL;
			mode_q  <= RST_MODE;
			src_q   <= RST_SPD_SRC;
			sset_q  <= RST_SPD_SET;
			tgt_q   <= RST_TGT_POS;
			pspd_q  <= RST_POS_SPD;
			acc_q   <= RST_ACCEL;
			dec_q   <= RST_DECEL;
			rdata_q <= 32'h0000_0000;
		end else begin
			jog_q   <= jog_d;
			ctrl_q  <= ctrl_d;
			mode_q  <= mode_d;
			src_q   <= src_d;
			sset_q  <= sset_d;
			tgt_q   <= tgt_d;
			pspd_q  <= pspd_d;
			acc_q   <= acc_d;
			dec_q   <= dec_d;
			rdata_q <= rdata_d;
		end
	end

	assign par_rdata_o = rdata_q;

	// ------------------------------------------------------------
	// Jog pin synchroniser
	// ------------------------------------------------------------
	// Three stages; a level is taken only once stages two and three
	// agree, which also rejects single-cycle glitches.
	logic [2:0] s1_q, s2_q, s3_q, pin_q, pin_d;

	always_comb begin
		pin_d = (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s1_q  <= 3'h0;
			s2_q  <= 3'h0;
			s3_q  <= 3'h0;
			pin_q <= 3'h0;
		end else begin
			s1_q  <= {jog_fast_pin_i, jog_neg_pin_i, jog_pos_pin_i};
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			pin_q <= pin_d;
		end
	end

	// ------------------------------------------------------------
	// Mode sequencing
	// ------------------------------------------------------------
	dms_state_t         st_q, st_d;
	dms_pos_set_t       cur_set, pend_q, pend_d, set_q, set_d;
	logic               bit4_q, vld_q, vld_d, move_q, move_d;
	logic               reach_q, reach_d, ack_q, ack_d, xend_q, xend_d;
	logic               spd_run_q, spd_run_d, err_q, ref_q;
	logic               jrun_q, jrun_d, jneg_q, jneg_d, jfast_q, jfast_d;
	logic               sact_q, sact_d, load_q, load_d;
	logic signed [15:0] sref_q, sref_d;
	logic [2:0]         jreq;
	logic               stop, pp_edge, done;
	logic signed [16:0] lim, val;

	assign jreq    = jog_src_io_i ? pin_q : jog_q;
	assign stop    = fb_i.halt | fb_i.err;
	assign pp_edge = (st_q == ST_PP) && ctrl_q[CW_NEW_SET] && !bit4_q;
	assign cur_set = {tgt_q, pspd_q, acc_q, dec_q, ctrl_q[CW_REL]};
	// The cycle after a load is skipped so a stale reached flag from
	// the previous target cannot end the new move.
	assign done    = move_q && !load_q && fb_i.standstill &&
	                 (fb_i.reached || stop);

	always_comb begin
		case (mode_q)
			MODE_JOG:   st_d = ST_JOG;
			MODE_SPEED: st_d = ST_SPEED;
			MODE_PP:    st_d = ST_PP;
			default:    st_d = ST_IDLE;
		endcase
		pend_d  = pend_q;
		set_d   = set_q;
		vld_d   = vld_q;
		move_d  = move_q;
		reach_d = reach_q;
		ack_d   = ack_q;
		load_d  = 1'b0;
		// Jog: exactly one direction, no interrupt
		jrun_d  = (st_q == ST_JOG) && !stop &&
		          (jreq[JOG_POS] ^ jreq[JOG_NEG]);
		jneg_d  = jreq[JOG_NEG];
		jfast_d = jreq[JOG_FAST];
		// Speed control: the loop shapes transitions, no ramp here
		spd_run_d = spd_run_q;
		if (st_q != ST_SPEED || fb_i.err) begin
			spd_run_d = 1'b0;
		end else if (src_wr) begin
			spd_run_d = (par_wdata_i[15:0] == SRC_PARAM);
		end
		sact_d = spd_run_q && !stop;
		lim = (max_speed_i > SPD_LIMIT[15:0]) ?
		      SPD_LIMIT : signed'({1'b0, max_speed_i});
		val = {sset_q[15], sset_q};
		if (val > lim) begin
			val = lim;
		end else if (val < -lim) begin
			val = -lim;
		end
		sref_d = sact_d ? val[15:0] : 16'sh0000;
		// Profile positioning
		if (done) begin
			if (fb_i.reached && !stop && vld_q) begin
				set_d  = pend_q;
				vld_d  = 1'b0;
				load_d = 1'b1;
			end else begin
				move_d  = 1'b0;
				reach_d = fb_i.reached && !stop;
			end
		end
		if (pp_edge) begin
			ack_d = 1'b1;
			if (ctrl_q[CW_IMMED] || !move_d) begin
				set_d   = cur_set;
				load_d  = 1'b1;
				move_d  = 1'b1;
				reach_d = 1'b0;
				vld_d   = 1'b0;
			end else begin
				pend_d = cur_set;
				vld_d  = 1'b1;
			end
		end else if (!ctrl_q[CW_NEW_SET]) begin
			ack_d = 1'b0;
		end
		if (st_q != ST_PP) begin
			vld_d   = 1'b0;
			move_d  = 1'b0;
			reach_d = 1'b0;
			ack_d   = 1'b0;
			load_d  = 1'b0;
		end
		case (st_q)
			ST_JOG:   xend_d = !jrun_d && fb_i.standstill;
			ST_SPEED: xend_d = !sact_d && fb_i.standstill;
			ST_PP:    xend_d = !move_d;
			default:  xend_d = fb_i.standstill;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q      <= ST_IDLE;
			pend_q    <= '0;
			set_q     <= '0;
			bit4_q    <= 1'b0;
			vld_q     <= 1'b0;
			move_q    <= 1'b0;
			reach_q   <= 1'b0;
			ack_q     <= 1'b0;
			xend_q    <= 1'b0;
			spd_run_q <= 1'b0;
			err_q     <= 1'b0;
			ref_q     <= 1'b0;
			jrun_q    <= 1'b0;
			jneg_q    <= 1'b0;
			jfast_q   <= 1'b0;
			sact_q    <= 1'b0;
			sref_q    <= 16'sh0000;
			load_q    <= 1'b0;
		end else begin
			st_q      <= st_d;
			pend_q    <= pend_d;
			set_q     <= set_d;
			bit4_q    <= ctrl_q[CW_NEW_SET];
			vld_q     <= vld_d;
			move_q    <= move_d;
			reach_q   <= reach_d;
			ack_q     <= ack_d;
			xend_q    <= xend_d;
			spd_run_q <= spd_run_d;
			err_q     <= fb_i.err;
			ref_q     <= fb_i.ref_ok;
			jrun_q    <= jrun_d;
			jneg_q    <= jneg_d;
			jfast_q   <= jfast_d;
			sact_q    <= sact_d;
			sref_q    <= sref_d;
			load_q    <= load_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign status_word_o = {ref_q, xend_q, err_q, ack_q, 1'b0, reach_q,
	                        10'h000};
	assign jog_run_o      = jrun_q;
	assign jog_neg_o      = jneg_q;
	assign jog_fast_o     = jfast_q;
	assign speed_active_o = sact_q;
	assign speed_ref_o    = sref_q;
	assign pos_load_o     = load_q;
	assign pos_set_o      = set_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	AST_JOG_BOTH: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i) jreq[JOG_POS] && jreq[JOG_NEG] |=> !jog_run_o)
		else $error("jog runs with both directions requested");
	AST_SPD_CLAMP: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i) speed_active_o |->
		speed_ref_o <= signed'(SPD_LIMIT[15:0]) &&
		speed_ref_o >= -signed'(SPD_LIMIT[15:0]) &&
		signed'({speed_ref_o[15], speed_ref_o}) <=
		signed'({1'b0, $past(max_speed_i)}) &&
		signed'({speed_ref_o[15], speed_ref_o}) >=
		-signed'({1'b0, $past(max_speed_i)}))
		else $error("speed reference outside the clamp limits");
	AST_SRC_LEGAL: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i) src_q == SRC_NONE || src_q == SRC_PARAM)
		else $error("illegal reference source value held");
	AST_ACK_EDGE: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i) pp_edge |=> status_word_o[SW_MODE12])
		else $error("setpoint acknowledge missing after edge");
	AST_LEVEL_ONLY: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i) !pp_edge && !(done && vld_q) |=> !pos_load_o)
		else $error("move loaded without a rising edge");
	AST_IMMED: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i) pp_edge && ctrl_q[CW_IMMED] |=>
		pos_load_o && pos_set_o == $past(cur_set))
		else $error("immediate set not applied");
	AST_HALT_NO_REACH: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i) st_q == ST_PP && done && stop && !pp_edge |=>
		!status_word_o[SW_REACHED] && status_word_o[SW_END])
		else $error("target reached shown after halt or error");
	AST_ERR_BIT: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i) fb_i.err |=> status_word_o[SW_ERR])
		else $error("error bit not shown");
	AST_REF_BIT: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i) fb_i.ref_ok |=> status_word_o[SW_REF])
		else $error("reference bit not shown");
	AST_JOG_BITS: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i) st_q == ST_JOG ##1 st_q == ST_JOG |->
		!status_word_o[SW_REACHED] && !status_word_o[SW_MODE12])
		else $error("bits 10 or 12 set in jog mode");

endmodule : dms_sequencer

//--- design/dms_pkg.sv
/*
 * Shared constants and carrier types for the drive mode sequencer.
 * Assumes a single 100 MHz core clock and an active-low async reset.
 */
package dms_pkg;

	// ------------------------------------------------------------
	// Parameter addresses
	// ------------------------------------------------------------
	localparam logic [15:0] ADDR_ACCEL   = 16'h0614;
	localparam logic [15:0] ADDR_DECEL   = 16'h0616;
	localparam logic [15:0] ADDR_CTRL    = 16'h1A00;
	localparam logic [15:0] ADDR_STATUS  = 16'h1A02;
	localparam logic [15:0] ADDR_MODE    = 16'h1A04;
	localparam logic [15:0] ADDR_JOG_REQ = 16'h1B12;
	localparam logic [15:0] ADDR_TGT_POS = 16'h1B1C;
	localparam logic [15:0] ADDR_POS_SPD = 16'h1B1E;
	localparam logic [15:0] ADDR_SPD_SRC = 16'h1B22;
	localparam logic [15:0] ADDR_SPD_SET = 16'h2108;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CW_NEW_SET  = 4;
	localparam int CW_IMMED    = 5;
	localparam int CW_REL      = 6;
	localparam int SW_REACHED  = 10;
	localparam int SW_MODE12   = 12;
	localparam int SW_ERR      = 13;
	localparam int SW_END      = 14;
	localparam int SW_REF      = 15;
	localparam int JOG_POS     = 0;
	localparam int JOG_NEG     = 1;
	localparam int JOG_FAST    = 2;

	// ------------------------------------------------------------
	// Reset values and limits
	// ------------------------------------------------------------
	localparam logic [2:0]  RST_JOG     = 3'h0;
	localparam logic [15:0] RST_CTRL    = 16'h0000;
	localparam logic [15:0] RST_MODE    = 16'h0000;
	localparam logic [15:0] RST_SPD_SRC = 16'h0000;
	localparam logic [15:0] RST_SPD_SET = 16'h0000;
	localparam logic [31:0] RST_TGT_POS = 32'h0000_0000;
	localparam logic [31:0] RST_POS_SPD = 32'h0000_003C;
	localparam logic [31:0] RST_ACCEL   = 32'h0000_0258;
	localparam logic [31:0] RST_DECEL   = 32'h0000_02EE;
	localparam logic [15:0] SRC_NONE    = 16'h0000;
	localparam logic [15:0] SRC_PARAM   = 16'h0002;
	localparam logic signed [16:0] SPD_LIMIT = 17'sh07530;

	// ------------------------------------------------------------
	// Mode codes and types
	// ------------------------------------------------------------
	localparam logic [15:0] MODE_PP    = 16'h0001;
	localparam logic [15:0] MODE_JOG   = 16'hFFFF;
	localparam logic [15:0] MODE_SPEED = 16'hFFFD;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_JOG   = 4'h2,
		ST_SPEED = 4'h4,
		ST_PP    = 4'h8
	} dms_state_t;

	typedef struct packed {
		logic [31:0] target;
		logic [31:0] speed;
		logic [31:0] accel;
		logic [31:0] decel;
		logic        relative;
	} dms_pos_set_t;

	typedef struct packed {
		logic standstill;
		logic reached;
		logic halt;
		logic err;
		logic ref_ok;
	} dms_motion_fb_t;

endpackage : dms_pkg

//--- dv/dms_master.sv
/* Fieldbus master model: one-cycle write and read strobes.
 * Assumes the sequencer samples strobes on the rising core clock. */
module dms_master
	import dms_pkg::*;
(
	// Clock
	input  wire logic        core_clk_i,
	// Parameter bus
	output logic             par_wr_o,
	output logic             par_rd_o,
	output logic [15:0]      par_addr_o,
	output logic [31:0]      par_wdata_o,
	input  wire logic [31:0] par_rdata_i
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		par_wr_o    = 1'b0;
		par_rd_o    = 1'b0;
		par_addr_o  = 16'h0000;
		par_wdata_o = 32'h0000_0000;
	end

	// Idle bus shows inverted values so stale data never looks valid
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		par_wr_o    <= 1'b1;
		par_addr_o  <= a;
		par_wdata_o <= d;
		@(posedge core_clk_i);
		par_wr_o    <= 1'b0;
		par_addr_o  <= ~a;
		par_wdata_o <= ~d;
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		@(posedge core_clk_i);
		par_rd_o   <= 1'b1;
		par_addr_o <= a;
		@(posedge core_clk_i);
		par_rd_o   <= 1'b0;
		par_addr_o <= ~a;
		#1 d = par_rdata_i;
	endtask : rd
endmodule : dms_master

//--- dv/tb_dms_sequencer.sv
/* Self-checking bench for the drive mode sequencer.
 * Assumes the master model drives the parameter bus. */
module tb_dms_sequencer
	import dms_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic           clk = 1'b0;
	logic           rst_b;
	logic           wr, rd, jsrc, jp, jn, jf;
	logic [15:0]    addr, maxs, sw;
	logic [31:0]    wdat, rdat, d;
	dms_motion_fb_t fb;
	logic           run, neg, fast, act, load;
	logic [15:0]    sref;
	dms_pos_set_t   set, last;
	int             loads, cycles, error_cnt, tests_run;

	always #5 clk = ~clk;

	dms_master host (.core_clk_i(clk), .par_wr_o(wr), .par_rd_o(rd),
		.par_addr_o(addr), .par_wdata_o(wdat), .par_rdata_i(rdat));

	dms_sequencer dut (.core_clk_i(clk), .rst_b_i(rst_b), .par_wr_i(wr),
		.par_rd_i(rd), .par_addr_i(addr), .par_wdata_i(wdat),
		.par_rdata_o(rdat), .jog_src_io_i(jsrc), .jog_pos_pin_i(jp),
		.jog_neg_pin_i(jn), .jog_fast_pin_i(jf), .fb_i(fb),
		.max_speed_i(maxs), .status_word_o(sw), .jog_run_o(run),
		.jog_neg_o(neg), .jog_fast_o(fast), .speed_active_o(act),
		.speed_ref_o(sref), .pos_load_o(load), .pos_set_o(set));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (load === 1'b1) begin
			loads <= loads + 1;
			last  <= set;
		end
		cycles <= cycles + 1;
		// Hang guard, far above the few hundred cycles needed
		if (cycles == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end

	task automatic chk(input logic [63:0] got, exp, input string m);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	// Feedback order: standstill, reached, halt, err, ref_ok
	task automatic setfb(input logic [4:0] v);
		@(posedge clk);
		fb <= v;
	endtask : setfb

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		logic [15:0] ra [6];
		logic [31:0] rv [6];
		ra = '{ADDR_ACCEL, ADDR_DECEL, ADDR_POS_SPD, ADDR_SPD_SRC,
			ADDR_SPD_SET, 16'h0100};
		rv = '{RST_ACCEL, RST_DECEL, RST_POS_SPD, 32'h0, 32'h0, 32'h0};
		for (int i = 0; i < 6; i++) begin
			host.rd(ra[i], d);
			chk(d, rv[i], "reset value");
		end
		chk(sw & 16'h0BFF, 16'h0, "unused status bits");
		chk(sw[15], 1'b1, "ref ok");
		setfb(5'b10010);
		cyc(3);
		chk({sw[15], sw[13]}, 2'b01, "error and no ref");
		setfb(5'b10001);
		cyc(3);
		chk(sw[13], 1'b0, "error gone");
		host.rd(ADDR_STATUS, d);
		chk(d, 32'h0000_C000, "status over bus");
	endtask : t_reset

	task automatic t_jog;
		host.wr(ADDR_MODE, {16'h0, MODE_JOG});
		host.wr(ADDR_JOG_REQ, 32'h1);
		cyc(3);
		chk({run, neg, fast, sw[14]}, 4'b1000, "jog pos slow");
		host.wr(ADDR_JOG_REQ, 32'h6);
		cyc(3);
		chk({run, neg, fast}, 3'b111, "jog neg fast");
		chk({sw[12], sw[10]}, 2'b00, "jog bits 10 12");
		host.wr(ADDR_JOG_REQ, 32'h3);
		cyc(3);
		chk(run, 1'b0, "both directions");
		host.wr(ADDR_JOG_REQ, 32'h1);
		setfb(5'b10101);
		cyc(3);
		chk({run, sw[14]}, 2'b01, "jog halted");
		setfb(5'b10001);
		host.wr(ADDR_JOG_REQ, 32'h0);
		cyc(3);
		chk({run, sw[14]}, 2'b01, "jog ended");
		@(posedge clk);
		jsrc <= 1'b1;
		jn   <= 1'b1;
		cyc(10);
		chk({run, neg, fast}, 3'b110, "jog from pins");
		@(posedge clk);
		jn <= 1'b0;
		jf <= 1'b1;
		jp <= 1'b1;
		cyc(10);
		chk({run, neg, fast}, 3'b101, "jog pins fast");
		@(posedge clk);
		jp   <= 1'b0;
		jf   <= 1'b0;
		jsrc <= 1'b0;
	endtask : t_jog

	task automatic t_speed;
		host.wr(ADDR_MODE, {16'h0, MODE_SPEED});
		host.wr(ADDR_SPD_SET, 32'h0000_FC18);
		host.wr(ADDR_SPD_SRC, 32'h5);
		host.rd(ADDR_SPD_SRC, d);
		chk({d, act}, 33'h0, "bad source refused");
		host.wr(ADDR_SPD_SRC, {16'h0, SRC_PARAM});
		cyc(3);
		chk({act, sref, sw[14]}, 18'h3F830, "speed start");
		host.wr(ADDR_SPD_SET, 32'h0000_7918);
		host.rd(ADDR_SPD_SET, d);
		chk(d, 32'h0000_FC18, "out of range refused");
		@(posedge clk);
		maxs <= 16'h01F4;
		cyc(3);
		chk(sref, 16'hFE0C, "clamped");
		@(posedge clk);
		maxs <= 16'hFFFF;
		host.wr(ADDR_SPD_SET, 32'h0000_0064);
		cyc(3);
		chk(sref, 16'h0064, "direct step");
		setfb(5'b10101);
		cyc(3);
		chk(sref, 16'h0000, "halt");
		setfb(5'b10001);
		host.wr(ADDR_SPD_SRC, {16'h0, SRC_NONE});
		cyc(3);
		chk({act, sw[14], sw[12], sw[10]}, 4'b0100, "speed end");
	endtask : t_speed

	task automatic t_pp;
		host.wr(ADDR_MODE, {16'h0, MODE_PP});
		chk(sw[15], 1'b1, "homed before absolute move");
		host.wr(ADDR_TGT_POS, 32'd100);
		host.wr(ADDR_CTRL, 32'h0010);
		cyc(3);
		chk({loads, last.target}, {32'd1, 32'd100}, "first load");
		chk(sw[12], 1'b1, "acknowledge");
		setfb(5'b00001);
		host.wr(ADDR_CTRL, 32'h0010);
		cyc(3);
		chk(loads, 32'd1, "level only");
		host.wr(ADDR_CTRL, 32'h0);
		cyc(3);
		chk(sw[12], 1'b0, "ack cleared");
		host.wr(ADDR_TGT_POS, 32'd200);
		host.wr(ADDR_CTRL, 32'h0010);
		host.wr(ADDR_CTRL, 32'h0);
		host.wr(ADDR_TGT_POS, 32'd300);
		host.wr(ADDR_ACCEL, 32'h1234);
		host.wr(ADDR_CTRL, 32'h0050);
		host.wr(ADDR_CTRL, 32'h0);
		cyc(3);
		chk(loads, 32'd1, "buffered");
		setfb(5'b11001);
		setfb(5'b00001);
		cyc(3);
		chk({loads, last.target}, {32'd2, 32'd300}, "newest set");
		chk({last.accel, last.relative}, {32'h1234, 1'b1}, "set");
		chk({last.speed, last.decel}, {RST_POS_SPD, RST_DECEL}, "spd dec");
		chk(sw[14], 1'b0, "still moving");
		host.wr(ADDR_TGT_POS, 32'd400);
		host.wr(ADDR_CTRL, 32'h0030);
		cyc(3);
		chk({loads, last.target}, {32'd3, 32'd400}, "immediate");
		chk(last.relative, 1'b0, "absolute");
		host.wr(ADDR_CTRL, 32'h0);
		setfb(5'b11001);
		cyc(3);
		chk({sw[14], sw[10]}, 2'b11, "target reached");
		host.wr(ADDR_CTRL, 32'h0010);
		setfb(5'b00001);
		host.wr(ADDR_CTRL, 32'h0);
		setfb(5'b10101);
		cyc(3);
		chk({loads, sw[14], sw[10]}, {32'd4, 2'b10}, "halted");
		setfb(5'b10001);
	endtask : t_pp

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst_b     = 1'b0;
		{jsrc, jp, jn, jf} = 4'h0;
		maxs      = 16'hFFFF;
		fb        = 5'b10001;
		loads     = 0;
		cycles    = 0;
		error_cnt = 0;
		tests_run = 0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_jog();
		t_speed();
		t_pp();
		wrap_up();
	end
endmodule : tb_dms_sequencer
